/* File: logic/qdl_loader.sv */
`timescale 1ns/10ps
`default_nettype none
module qdl_loader
  import qdl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  bus_mode,
  input  wire logic [1:0]  dec_mode,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic        base_match,
  input  wire qdl_wr_t     wr_req,
  input  wire logic        conv_start,
  input  wire logic        comp_in,
  output logic             conv_busy,
  output logic             conv_done,
  output logic [11:0]      conv_result,
  output logic             dac_one_select_n,
  output logic             dac_two_select_n,
  output logic             dac_three_select_n,
  output logic             dac_four_select_n,
  output logic [11:0]      dac_data_o,
  output logic [11:0]      dac_data_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_SAR_SET, ST_SAR_WAIT} qdl_state_t;

  qdl_state_t  state_r;
  qdl_wr_t     buf_q;
  logic        buf_valid;
  logic        buf_pop;
  qdl_load_t   load_r;
  logic        drive_r;
  logic        strobe_r;
  logic [15:0] cnt_r;
  logic [7:0]  low_byte_r;
  logic        byte_half_r;
  logic [11:0] sar_r;
  logic [3:0]  bit_r;
  logic [3:0]  sel_dec;
  logic [11:0] code_sel;
  logic        emit;
  logic        cmp_s1_r;
  logic        cmp_s2_r;
  logic        cmp_s3_r;
  logic        cmp_r;
  logic [17:0] conv_time_r;

  qdl_skid_buf u_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_req),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_q)
  );

  assign buf_pop = (state_r == ST_IDLE) && buf_valid && !conv_start;

  // comparator pin is asynchronous: three stages, change accepted when 2 and 3 agree
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      cmp_r    <= 1'b0;
    end
    else
    begin
      cmp_s1_r <= comp_in;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r)
      begin
        cmp_r <= cmp_s3_r;
      end
    end
  end

  always_comb
  begin
    sel_dec = 4'hf;
    if (dec_mode == DEC_PER_LINE)
    begin
      sel_dec = {2'h3, ~buf_q.addr};
    end
    else
    begin
      sel_dec[buf_q.addr] = 1'b0;
    end
  end

  always_comb
  begin
    case (bus_mode)
      MODE_W16_LEFT:  code_sel = buf_q.data[15:4];
      MODE_B8:        code_sel = {buf_q.data[3:0], low_byte_r};
      default:        code_sel = buf_q.data[11:0];
    endcase
  end

  // 8-bit bus: first byte only fills the holding latch, no load
  assign emit = (bus_mode != MODE_B8) || byte_half_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      low_byte_r  <= 8'h00;
      byte_half_r <= 1'b0;
    end
    else if (buf_pop && bus_mode == MODE_B8)
    begin
      if (!byte_half_r)
      begin
        low_byte_r <= buf_q.data[7:0];
      end
      byte_half_r <= ~byte_half_r;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r     <= ST_IDLE;
      load_r      <= '{sel_n: 4'hf, code: 12'h000};
      drive_r     <= 1'b0;
      strobe_r    <= 1'b0;
      cnt_r       <= 16'h0000;
      sar_r       <= 12'h000;
      bit_r       <= 4'h0;
      conv_result <= 12'h000;
      conv_done   <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          drive_r  <= 1'b0;
          strobe_r <= 1'b0;
          if (conv_start)
          begin
            sar_r   <= 12'h800;
            bit_r   <= 4'hb;
            state_r <= ST_SAR_SET;
          end
          else if (buf_pop && emit && base_match)
          begin
            load_r  <= '{sel_n: sel_dec, code: code_sel};
            drive_r <= 1'b1;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          strobe_r <= 1'b1;
          cnt_r    <= 16'(SEL_PULSE_CYC - 1);
          state_r  <= ST_STROBE;
        end
        ST_STROBE:
        begin
          if (cnt_r == 16'h0000)
          begin
            strobe_r <= 1'b0;
            state_r  <= ST_IDLE;
          end
          else
          begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        ST_SAR_SET:
        begin
          // one channel reserved for the converter; others untouched
          load_r   <= '{sel_n: 4'he, code: sar_r};
          drive_r  <= 1'b1;
          strobe_r <= 1'b1;
          cnt_r    <= 16'(TRIAL_WAIT_CYC - 1);
          state_r  <= ST_SAR_WAIT;
        end
        ST_SAR_WAIT:
        begin
          if (cnt_r == 16'(TRIAL_WAIT_CYC - 1 - SEL_PULSE_CYC))
          begin
            strobe_r <= 1'b0;
          end
          if (cnt_r == 16'h0000)
          begin
            // comparator high means dac output above input: drop the bit
            if (cmp_r)
            begin
              sar_r[bit_r] <= 1'b0;
            end
            if (bit_r == 4'h0)
            begin
              conv_result <= cmp_r ? (sar_r & ~12'h001) : sar_r;
              conv_done   <= 1'b1;
              drive_r     <= 1'b0;
              state_r     <= ST_IDLE;
            end
            else
            begin
              sar_r[bit_r - 4'h1] <= 1'b1;
              bit_r   <= bit_r - 4'h1;
              state_r <= ST_SAR_SET;
            end
          end
          else
          begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      conv_time_r <= 18'h00000;
    end
    else if (state_r == ST_IDLE)
    begin
      conv_time_r <= 18'h00000;
    end
    else
    begin
      conv_time_r <= conv_time_r + 18'h00001;
    end
  end

  assign conv_busy          = (state_r == ST_SAR_SET) || (state_r == ST_SAR_WAIT);
  // selects gated by the strobe so latches load only in the window
  assign dac_one_select_n   = load_r.sel_n[0] | ~strobe_r;
  assign dac_two_select_n   = load_r.sel_n[1] | ~strobe_r;
  assign dac_three_select_n = load_r.sel_n[2] | ~strobe_r;
  assign dac_four_select_n  = load_r.sel_n[3] | ~strobe_r;
  // released pins read high by the board pull-ups
  assign dac_data_o         = drive_r ? load_r.code : CODE_ALL_ONES;
  assign dac_data_oe        = {CODE_W{drive_r}};

  property p_sel_needs_drive;
    @(posedge ref_clk) disable iff (sys_rst)
    !dac_one_select_n |-> (dac_data_oe == 12'hfff);
  endproperty
  a_sel_needs_drive: assert property (p_sel_needs_drive) else $error("select low while data undriven");

  property p_pulse_len;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(strobe_r) && !conv_busy |-> strobe_r[*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("select pulse too short");

  property p_sel_gated;
    @(posedge ref_clk) disable iff (sys_rst)
    (!dac_one_select_n || !dac_two_select_n || !dac_three_select_n || !dac_four_select_n)
      |-> (state_r == ST_STROBE || state_r == ST_SAR_WAIT);
  endproperty
  a_sel_gated: assert property (p_sel_gated) else $error("select outside load window");

  property p_released_high;
    @(posedge ref_clk) disable iff (sys_rst)
    !drive_r |-> (dac_data_o == 12'hfff);
  endproperty
  a_released_high: assert property (p_released_high) else $error("idle data not high");

  property p_conv_time;
    @(posedge ref_clk) disable iff (sys_rst)
    conv_done |-> (conv_time_r <= 18'(CONV_LIMIT_CYC));
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion too long");

  property p_sar_channel;
    @(posedge ref_clk) disable iff (sys_rst)
    conv_busy |-> (dac_two_select_n && dac_three_select_n && dac_four_select_n);
  endproperty
  a_sar_channel: assert property (p_sar_channel) else $error("converter touched other channel");

  property p_sar_keep;
    @(posedge ref_clk) disable iff (sys_rst)
    (state_r == ST_SAR_WAIT) && cnt_r == 16'h0000 && !cmp_r && bit_r != 4'h0 |=> sar_r[$past(bit_r)];
  endproperty
  a_sar_keep: assert property (p_sar_keep) else $error("kept bit lost");

  property p_byte_first_no_load;
    @(posedge ref_clk) disable iff (sys_rst)
    buf_pop && bus_mode == MODE_B8 && !byte_half_r |=> (state_r == ST_IDLE);
  endproperty
  a_byte_first_no_load: assert property (p_byte_first_no_load) else $error("first byte loaded dac");

  property p_perline;
    @(posedge ref_clk) disable iff (sys_rst)
    buf_pop && base_match && emit && dec_mode == DEC_PER_LINE && buf_q.addr == 2'h3 && !conv_start
      |=> load_r.sel_n == 4'hc;
  endproperty
  a_perline: assert property (p_perline) else $error("per-line decode wrong");

  c_load: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(dac_one_select_n));
  c_conv: cover property (@(posedge ref_clk) disable iff (sys_rst) conv_done);
  c_full: cover property (@(posedge ref_clk) disable iff (sys_rst) !wr_ready);
endmodule
`default_nettype wire

/* File: include/qdl_pkg.sv */
package qdl_pkg;
  localparam int CODE_W = 12;
  localparam int NUM_DAC = 4;
  localparam int CLK_PERIOD_NS = 25;
  // select low time must cover the 400 ns load pulse and 210 ns data setup
  localparam int SEL_PULSE_NS = 400;
  localparam int SEL_PULSE_CYC = (SEL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // one comparison trial: 15 us
  localparam int TRIAL_NS = 15000;
  localparam int TRIAL_CYC = (TRIAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // wait part of a trial; with its set cycle a trial is one cycle short of 15 us,
  // so twelve trials end inside the conversion limit
  localparam int TRIAL_WAIT_CYC = TRIAL_CYC - 2;
  localparam int CONV_LIMIT_NS = 180000;
  localparam int CONV_LIMIT_CYC = CONV_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [11:0] CODE_ALL_ONES = 12'hfff;
  localparam logic [1:0] MODE_W16_RIGHT = 2'h0;
  localparam logic [1:0] MODE_W16_LEFT = 2'h1;
  localparam logic [1:0] MODE_B8 = 2'h2;
  localparam logic [1:0] DEC_BINARY = 2'h0;
  localparam logic [1:0] DEC_PER_LINE = 2'h1;
  localparam logic [15:0] SAR_CHAN_SEL_N = 16'h0000;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] data;
  } qdl_wr_t;

  typedef struct packed {
    logic [3:0]  sel_n;
    logic [11:0] code;
  } qdl_load_t;
endpackage

/* File: logic/qdl_skid_buf.sv */
`timescale 1ns/10ps
`default_nettype none
module qdl_skid_buf
  import qdl_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    sys_rst,
  input  wire logic    in_valid,
  output logic         in_ready,
  input  wire qdl_wr_t in_data,
  output logic         out_valid,
  input  wire logic    out_ready,
  output qdl_wr_t      out_data
);
  qdl_wr_t     mem_r [2];
  logic        wp_r;
  logic        rp_r;
  logic [1:0]  cnt_r;
  logic        push;
  logic        pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= ~wp_r;
      end
      if (pop)
      begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

/* File: verification/qdl_dac_model.sv */
`timescale 1ns/10ps
`default_nettype none
module qdl_dac_model
  import qdl_pkg::*;
(
  input  wire logic [3:0]       sel_n,
  input  wire logic [11:0]      data_o,
  input  wire logic [11:0]      data_oe,
  input  wire logic [11:0]      unknown_in,
  output logic      [3:0][11:0] level,
  output logic                  comp_out
);
  logic [11:0] pin;

  // undriven bits float to the pull-up level, never to a stale value
  always_comb
  begin
    for (int i = 0; i < CODE_W; i++)
      pin[i] = data_oe[i] ? data_o[i] : 1'b1;
  end

  // transparent while the select is low, holds once it returns high
  always_latch
  begin
    for (int k = 0; k < NUM_DAC; k++)
      if (!sel_n[k])
        level[k] = pin;
  end

  // high when the first output stands above the unknown input
  assign comp_out = (level[0] > unknown_in);
endmodule
`default_nettype wire

/* File: verification/tb_quad_dac_bus_loader.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_quad_dac_bus_loader;
  import qdl_pkg::*;
  localparam int CYC_CEIL = 20000;
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [1:0]       bus_mode = MODE_W16_RIGHT;
  logic [1:0]       dec_mode = DEC_BINARY;
  logic             wr_valid = 1'b0;
  logic             wr_ready;
  logic             base_match = 1'b1;
  qdl_wr_t          wr_req = '0;
  logic             conv_start = 1'b0;
  logic             comp;
  logic             conv_busy;
  logic             conv_done;
  logic [11:0]      conv_result;
  logic [3:0]       sel_n;
  logic [11:0]      dac_data_o;
  logic [11:0]      dac_data_oe;
  logic [11:0]      unknown = 12'h5a3;
  logic [3:0][11:0] level;
  int               err_count = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  qdl_loader u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_mode(bus_mode), .dec_mode(dec_mode),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .base_match(base_match), .wr_req(wr_req),
    .conv_start(conv_start), .comp_in(comp), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_result(conv_result), .dac_one_select_n(sel_n[0]), .dac_two_select_n(sel_n[1]),
    .dac_three_select_n(sel_n[2]), .dac_four_select_n(sel_n[3]), .dac_data_o(dac_data_o),
    .dac_data_oe(dac_data_oe));

  qdl_dac_model u_dac (.sel_n(sel_n), .data_o(dac_data_o), .data_oe(dac_data_oe), .unknown_in(unknown),
    .level(level), .comp_out(comp));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held from one edge until the edge where ready is high
  task automatic push(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_req   <= '{addr: a, data: d};
    @(negedge ref_clk);
    while (wr_ready !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
    wr_valid <= 1'b0;
  endtask

  // one load takes eighteen cycles from the pop until the driver lets go
  task automatic settle(input int n);
    repeat (25 * n) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    @(negedge ref_clk);
    chk("selects", 16'h000f, {12'h000, sel_n});
    chk("data_oe", 16'h0000, {4'h0, dac_data_oe});
    chk("data_o", 16'h0fff, {4'h0, dac_data_o});
    chk("wr_ready", 16'h0001, {15'h0, wr_ready});
    chk("busy", 16'h0000, {15'h0, conv_busy});
    $display("test reset done");
  endtask

  task automatic t_decode;
    for (int a = 0; a < NUM_DAC; a++)
    begin
      push(a[1:0], 16'ha000 | (16'h0321 * a[15:0] + 16'h0101));
      settle(1);
      chk("binary load", (16'h0321 * a[15:0] + 16'h0101), {4'h0, level[a]});
    end
    $display("test decode done");
  endtask

  task automatic t_left;
    bus_mode <= MODE_W16_LEFT;
    push(2'h2, 16'h9c3e);
    settle(1);
    chk("left load", 16'h09c3, {4'h0, level[2]});
    chk("left others", 16'h0a64, {4'h0, level[3]});
    $display("test left done");
  endtask

  task automatic t_perline;
    bus_mode <= MODE_W16_RIGHT;
    dec_mode <= DEC_PER_LINE;
    push(2'h3, 16'hf777);
    settle(1);
    chk("line one", 16'h0777, {4'h0, level[0]});
    chk("line two", 16'h0777, {4'h0, level[1]});
    chk("line three", 16'h09c3, {4'h0, level[2]});
    dec_mode <= DEC_BINARY;
    $display("test perline done");
  endtask

  task automatic t_nobase;
    base_match <= 1'b0;
    push(2'h3, 16'h0abc);
    // a wrong load would hold its select low from the second edge after the push
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("no base sel", 16'h000f, {12'h000, sel_n});
    settle(1);
    chk("no base", 16'h0a64, {4'h0, level[3]});
    base_match <= 1'b1;
    $display("test nobase done");
  endtask

  task automatic t_bytes;
    bus_mode <= MODE_B8;
    push(2'h1, 16'hff5a);
    settle(1);
    chk("first byte", 16'h0777, {4'h0, level[1]});
    push(2'h1, 16'h00f3);
    settle(1);
    chk("byte merge", 16'h035a, {4'h0, level[1]});
    bus_mode <= MODE_W16_RIGHT;
    $display("test bytes done");
  endtask

  task automatic t_burst;
    push(2'h0, 16'h0123);
    push(2'h3, 16'h0456);
    push(2'h0, 16'h0789);
    settle(3);
    chk("burst one", 16'h0789, {4'h0, level[0]});
    chk("burst four", 16'h0456, {4'h0, level[3]});
    $display("test burst done");
  endtask

  task automatic t_conv;
    int n;
    n = 0;
    @(posedge ref_clk);
    conv_start <= 1'b1;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    @(negedge ref_clk);
    chk("busy", 16'h0001, {15'h0, conv_busy});
    while (conv_done !== 1'b1 && n < CONV_LIMIT_CYC)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("conv in time", 16'h0001, {15'h0, (n < CONV_LIMIT_CYC)});
    chk("conv result", {4'h0, unknown}, {4'h0, conv_result});
    chk("others kept", 16'h0456, {4'h0, level[3]});
    $display("test conv done");
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == CYC_CEIL)
    begin
      err_count++;
      $display("wrong value cycle limit expected %0d seen %0d", CYC_CEIL - 1, cyc);
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_decode();
    t_left();
    t_perline();
    t_nobase();
    t_bytes();
    t_burst();
    t_conv();
    tally_and_finish();
  end
endmodule
`default_nettype wire
